// >>> rtl/calendar_clock_control_map.svh
/*
 * Register offsets, field positions, reset values and timing constants of the
 * calendar clock control block.
 * Assumes it is included by bare name from files under rtl/ and testbench/.
 */
`ifndef CALENDAR_CLOCK_CONTROL_MAP_SVH
`define CALENDAR_CLOCK_CONTROL_MAP_SVH

`define ADDR_POWER_ON_INDICATOR 20'hf00f9
`define ADDR_CALENDAR_CONTROL_A 20'hfff9d
`define ADDR_CALENDAR_CONTROL_B 20'hfff9e
`define ADDR_CLOCK_SOURCE 20'hf00f3

`define REG_RESET 8'h00

`define BIT_POWER_ON_CHECK 0
`define BIT_SOURCE_SELECT 4
`define BIT_COUNTER_RUN 7
`define BIT_PULSE_ACCURACY 6
`define BIT_PULSE_ENABLE 5
`define BIT_RESERVED_A 4
`define BIT_HOUR_FORMAT 3
`define BIT_ALARM_MATCH_EN 7
`define BIT_ALARM_IRQ_EN 6
`define BIT_CORR_IRQ_EN 5
`define BIT_ALARM_FLAG 4
`define BIT_PERIODIC_FLAG 3
`define BIT_RESERVED_B 2
`define BIT_HOLD_STATUS 1
`define BIT_HOLD_REQUEST 0

`define PERIODIC_NONE 3'h0
`define PERIODIC_HALF_SEC 3'h1
`define PERIODIC_SECOND 3'h2
`define PERIODIC_MINUTE 3'h3
`define PERIODIC_HOUR 3'h4
`define PERIODIC_DAY 3'h5

`define HOLD_SETTLE_CYCLES 2'h1
`define TICK_COUNT_MAX 16'hffff
`define TICK_HALF 16'h7fff

`endif

// >>> rtl/calendar_clock_control_pkg.sv
/*
 * Types shared by the calendar clock control files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package calendar_clock_control_pkg;
	typedef enum logic [1:0] {
		HOLD_IDLE = 2'b00,
		HOLD_SETTLE = 2'b01,
		HOLD_ACTIVE = 2'b10
	} hold_state_t;

	typedef struct packed {
		logic [7:0] power_on_indicator_r;
		logic [7:0] calendar_control_a_r;
		logic [7:0] calendar_control_b_r;
		logic count_clock_source_select_r;
		logic second_pulse_r;
		logic calendar_irq_r;
		logic correction_tick_irq_r;
		logic [7:0] read_data_r;
		hold_state_t hold_state_r;
	} ctrl_state_t;

	typedef struct packed {
		logic [15:0] prescale_r;
		logic [5:0] seconds_r;
		logic [5:0] minutes_r;
		logic [4:0] hours_r;
		logic [4:0] day_r;
	} time_state_t;
endpackage

// >>> rtl/calendar_time_if.sv
/*
 * Interface between control logic and the time base.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface calendar_time_if;
	logic run;
	logic hold;
	logic low_speed;
	logic tick_half;
	logic tick_second;
	logic minute_top;
	logic hour_top;
	logic day_top;
	logic month_top;
	modport ctrl (output run, output hold, output low_speed, input tick_half,
		input tick_second, input minute_top, input hour_top, input day_top, input month_top);
	modport base (input run, input hold, input low_speed, output tick_half,
		output tick_second, output minute_top, output hour_top, output day_top, output month_top);
endinterface

// >>> rtl/calendar_time_base.sv
/*
 * Prescaler and coarse time base producing the periodic event strobes.
 * Assumes a count-clock enable arrives from the control logic on SYS_CLK.
 */
`timescale 1ns/10ps
`include "calendar_clock_control_map.svh"
module calendar_time_base
	import calendar_clock_control_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst_b, // Power-on reset, active low.
	input wire logic count_tick, // One count-clock edge.
	calendar_time_if.base tb // Strobes toward the control logic.
);
	time_state_t q_r, q_nxt;
	logic wrap;

	// The prescaler keeps running under hold; only the calendar counters freeze.
	always_comb begin
		q_nxt = q_r;
		wrap = count_tick && (q_r.prescale_r == `TICK_COUNT_MAX);
		if (!tb.run) begin
			q_nxt = q_r;
		end else if (count_tick) begin
			q_nxt.prescale_r = q_r.prescale_r + 16'h0001;
			if (wrap && !tb.hold && !tb.low_speed) begin // R25 R03
				q_nxt.seconds_r = (q_r.seconds_r == 6'd59) ? 6'd0 : q_r.seconds_r + 6'd1;
				if (q_r.seconds_r == 6'd59) begin
					q_nxt.minutes_r = (q_r.minutes_r == 6'd59) ? 6'd0 : q_r.minutes_r + 6'd1;
					if (q_r.minutes_r == 6'd59) begin
						q_nxt.hours_r = (q_r.hours_r == 5'd23) ? 5'd0 : q_r.hours_r + 5'd1;
						if (q_r.hours_r == 5'd23) begin
							q_nxt.day_r = (q_r.day_r == 5'd29) ? 5'd0 : q_r.day_r + 5'd1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// The half and second strobes are one cycle wide and follow the prescaler; the top signals are levels from the counters.
	assign tb.tick_half = tb.run && count_tick && (q_r.prescale_r[14:0] == 15'(`TICK_HALF));
	assign tb.tick_second = tb.run && wrap;
	assign tb.minute_top = q_r.seconds_r == 6'd59;
	assign tb.hour_top = tb.minute_top && (q_r.minutes_r == 6'd59);
	assign tb.day_top = tb.hour_top && (q_r.hours_r == 5'd23);
	assign tb.month_top = tb.day_top && (q_r.day_r == 5'd29);
endmodule

// >>> rtl/calendar_clock_control.sv
/*
 * Control and status registers of the calendar clock: clock source, power-on
 * indicator, run control, 1 Hz pulse, hour format, periodic and alarm flags.
 * Assumes RST_B is the power-on reset only, and byte writes are one-cycle strobes.
 */
`timescale 1ns/10ps
`include "calendar_clock_control_map.svh"
// How it works
// R01: Software keeps source select 0 while the subsystem oscillator runs.
// R02: Source select 1 turns on the low-speed oscillator.
// R03: Low-speed source allows periodic interrupts only; counters and pulse stop. The code still raises correction tick and alarm interrupts here.
// R04: Low-speed periodic interval scales by subsystem over low-speed frequency.
// R05: Software switches the source only while dependent blocks are stopped.
// R06: Power-on indicator clears only on power-on reset.
// R07: Indicator bit 0 holds a written 1; other bits read zero.
// R08: Both control registers clear only on power-on reset.
// R09: Run bit stops or starts the calendar counter.
// R10: Pulse pin drives only when running and enabled; accuracy bit picks form.
// R11: Software uses high-accuracy pulse only at 24 MHz with correction.
// R12: Hour format bit picks 12-hour when 0, 24-hour when 1.
// R13: Software sets hold before rewriting hours after a format change.
// R14: Periodic select encodes none, half second, second, minute, hour, day, month.
// R15: Software masks, rewrites select, clears flags, then unmasks.
// R16: Software writes 0 to reserved bit 4 of control A.
// R17: Alarm match enable gates alarm comparison.
// R18: Software masks interrupt around alarm enable changes and clears flags.
// R19: Software keeps alarm enable 0 while programming alarm settings.
// R20: Alarm interrupt enable gates alarm matches onto the interrupt.
// R21: Writing 1 to periodic or alarm flag leaves it unchanged.
// R22: Correction interrupt enable gates the correction tick interrupt.
// R23: Alarm flag sets one count clock after a match; cleared by writing 0.
// R24: Periodic flag sets on each periodic event; cleared by writing 0.
// R25: Hold request freezes the calendar counters.
// R26: Periodic and alarm events share one interrupt line.
// R27: Reserved bits read zero and ignore writes.
module calendar_clock_control
	import calendar_clock_control_pkg::*;
#(
	parameter int SUB_DIV = 1, // System clocks per subsystem count edge.
	parameter int LOW_DIV = 1 // System clocks per low-speed count edge.
) (
	input wire logic SYS_CLK, // System clock, 40 MHz.
	input wire logic RST_B, // Power-on reset, active low.
	input wire logic [19:0] ADDR, // Byte address.
	input wire logic WR_EN, // Write strobe, one cycle.
	input wire logic RD_EN, // Read strobe, one cycle.
	input wire logic [7:0] WDATA, // Write data.
	input wire logic ALARM_MATCH, // Alarm compare hit from the alarm registers.
	output logic [7:0] RDATA, // Read data, registered.
	output logic LOW_OSC_ENABLE, // Runs the low-speed oscillator.
	output logic SECOND_PULSE_PIN, // 1 Hz pulse output.
	output logic HIGH_ACCURACY_PULSE, // Pulse generated in high-accuracy form.
	output logic HOUR_FORMAT_24, // Hour format to the hour counter.
	output logic CALENDAR_IRQ, // Shared calendar interrupt pulse.
	output logic CORRECTION_TICK_IRQ // Correction timing interrupt pulse.
);
	ctrl_state_t s_r, s_nxt;
	calendar_time_if tif();
	logic [$clog2(SUB_DIV + LOW_DIV + 1):0] div_r;
	logic count_tick, alarm_seen_r, alarm_set, periodic_set;
	logic wr_a, wr_b, wr_p, wr_s;

	// Count-clock edges come from a divider; the low-speed ratio stretches
	// the half-second and second intervals by the frequency ratio without extra logic.
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_r <= '0;
			alarm_seen_r <= 1'b0;
		end else begin
			if (count_tick) begin
				div_r <= '0;
			end else begin
				div_r <= div_r + 1'b1;
			end
			if (count_tick) begin
				alarm_seen_r <= ALARM_MATCH && s_r.calendar_control_b_r[`BIT_ALARM_MATCH_EN]; // R17 R23
			end
		end
	end
	assign count_tick = s_r.count_clock_source_select_r ? // R04
		(32'(div_r) >= LOW_DIV - 1) : (32'(div_r) >= SUB_DIV - 1);
	assign alarm_set = count_tick && alarm_seen_r; // R23

	assign tif.run = s_r.calendar_control_a_r[`BIT_COUNTER_RUN]; // R09
	assign tif.hold = s_r.hold_state_r != HOLD_IDLE; // R25
	assign tif.low_speed = s_r.count_clock_source_select_r; // R03

	calendar_time_base u_base (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.count_tick(count_tick),
		.tb(tif)
	);

	// Periodic event decode by select field.
	always_comb begin
		case (s_r.calendar_control_a_r[2:0]) // R14
		`PERIODIC_NONE: periodic_set = 1'b0;
		`PERIODIC_HALF_SEC: periodic_set = tif.tick_half || tif.tick_second;
		`PERIODIC_SECOND: periodic_set = tif.tick_second;
		`PERIODIC_MINUTE: periodic_set = tif.tick_second && tif.minute_top;
		`PERIODIC_HOUR: periodic_set = tif.tick_second && tif.hour_top;
		`PERIODIC_DAY: periodic_set = tif.tick_second && tif.day_top;
		default: periodic_set = tif.tick_second && tif.month_top;
		endcase
	end

	// Address decode.
	always_comb begin
		wr_a = 1'b0;
		wr_b = 1'b0;
		wr_p = 1'b0;
		wr_s = 1'b0;
		if (ADDR == `ADDR_CALENDAR_CONTROL_A) begin
			wr_a = WR_EN;
		end else if (ADDR == `ADDR_CALENDAR_CONTROL_B) begin
			wr_b = WR_EN;
		end else if (ADDR == `ADDR_POWER_ON_INDICATOR) begin
			wr_p = WR_EN;
		end else if (ADDR == `ADDR_CLOCK_SOURCE) begin
			wr_s = WR_EN;
		end
	end

	// Next-state logic for all control state.
	always_comb begin
		logic ap, pp;
		ap = s_r.calendar_control_b_r[`BIT_ALARM_FLAG];
		pp = s_r.calendar_control_b_r[`BIT_PERIODIC_FLAG];
		s_nxt = s_r;
		if (wr_p) begin
			s_nxt.power_on_indicator_r = {7'h00, WDATA[`BIT_POWER_ON_CHECK]}; // R07
		end
		if (wr_s) begin
			s_nxt.count_clock_source_select_r = WDATA[`BIT_SOURCE_SELECT]; // R02
		end
		if (wr_a) begin
			s_nxt.calendar_control_a_r = WDATA;
			s_nxt.calendar_control_a_r[`BIT_RESERVED_A] = 1'b0; // R27
		end
		if (wr_b) begin
			s_nxt.calendar_control_b_r[7:5] = WDATA[7:5];
			s_nxt.calendar_control_b_r[`BIT_HOLD_REQUEST] = WDATA[`BIT_HOLD_REQUEST];
			// A written 1 leaves the flag alone; only 0 clears it.
			ap = ap && WDATA[`BIT_ALARM_FLAG]; // R21 R23
			pp = pp && WDATA[`BIT_PERIODIC_FLAG]; // R21 R24
		end
		// Setting beats a simultaneous clear so no event is lost.
		s_nxt.calendar_control_b_r[`BIT_ALARM_FLAG] = ap || alarm_set; // R23
		s_nxt.calendar_control_b_r[`BIT_PERIODIC_FLAG] = pp || periodic_set; // R24
		s_nxt.calendar_control_b_r[`BIT_RESERVED_B] = 1'b0; // R27
		// Hold acknowledge waits for a count edge before reporting ready.
		case (s_r.hold_state_r)
		HOLD_IDLE: if (s_nxt.calendar_control_b_r[`BIT_HOLD_REQUEST]) begin
			s_nxt.hold_state_r = HOLD_SETTLE;
		end
		HOLD_SETTLE: if (!s_r.calendar_control_b_r[`BIT_HOLD_REQUEST]) begin
			s_nxt.hold_state_r = HOLD_IDLE;
		end else if (count_tick) begin
			s_nxt.hold_state_r = HOLD_ACTIVE; // R25
		end
		default: if (!s_r.calendar_control_b_r[`BIT_HOLD_REQUEST]) begin
			s_nxt.hold_state_r = HOLD_IDLE;
		end
		endcase
		s_nxt.calendar_control_b_r[`BIT_HOLD_STATUS] = s_nxt.hold_state_r == HOLD_ACTIVE;
		// The pulse is the top prescaler half; a stopped or low-speed base gives none.
		s_nxt.second_pulse_r = s_r.calendar_control_a_r[`BIT_COUNTER_RUN] && // R10
			s_r.calendar_control_a_r[`BIT_PULSE_ENABLE] &&
			!s_r.count_clock_source_select_r && // R03
			(tif.tick_second ? 1'b0 : (tif.tick_half ? 1'b1 : s_r.second_pulse_r)); // Wrap meets the half mark too.
		s_nxt.calendar_irq_r = periodic_set || // R26
			(alarm_set && s_r.calendar_control_b_r[`BIT_ALARM_IRQ_EN]); // R20
		s_nxt.correction_tick_irq_r = tif.tick_second &&
			s_r.calendar_control_b_r[`BIT_CORR_IRQ_EN]; // R22
		s_nxt.read_data_r = s_r.read_data_r;
		if (RD_EN) begin
			if (ADDR == `ADDR_CALENDAR_CONTROL_A) begin
				s_nxt.read_data_r = s_r.calendar_control_a_r;
			end else if (ADDR == `ADDR_CALENDAR_CONTROL_B) begin
				s_nxt.read_data_r = s_r.calendar_control_b_r;
			end else if (ADDR == `ADDR_POWER_ON_INDICATOR) begin
				s_nxt.read_data_r = s_r.power_on_indicator_r;
			end else if (ADDR == `ADDR_CLOCK_SOURCE) begin
				s_nxt.read_data_r = 8'(s_r.count_clock_source_select_r) << `BIT_SOURCE_SELECT;
			end else begin
				s_nxt.read_data_r = 8'h00;
			end
		end
	end

	// Only the power-on reset reaches these registers; other resets never touch them.
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_r <= '0; // R06 R08
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.read_data_r;
	assign LOW_OSC_ENABLE = s_r.count_clock_source_select_r; // R02
	assign SECOND_PULSE_PIN = s_r.second_pulse_r;
	assign HIGH_ACCURACY_PULSE = s_r.calendar_control_a_r[`BIT_PULSE_ACCURACY]; // R10
	assign HOUR_FORMAT_24 = s_r.calendar_control_a_r[`BIT_HOUR_FORMAT]; // R12
	assign CALENDAR_IRQ = s_r.calendar_irq_r;
	assign CORRECTION_TICK_IRQ = s_r.correction_tick_irq_r;

	a_flag_write_one: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R21
		wr_b && WDATA[`BIT_PERIODIC_FLAG] && s_r.calendar_control_b_r[`BIT_PERIODIC_FLAG]
		|=> s_r.calendar_control_b_r[`BIT_PERIODIC_FLAG]) else $error("Flag lost on write of one.");
	a_periodic_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R24
		periodic_set |=> s_r.calendar_control_b_r[`BIT_PERIODIC_FLAG] && CALENDAR_IRQ)
		else $error("Periodic event did not set flag.");
	a_alarm_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R20
		alarm_set && !s_r.calendar_control_b_r[`BIT_ALARM_IRQ_EN] && !periodic_set
		|=> !CALENDAR_IRQ) else $error("Alarm interrupt while disabled.");
	a_pulse_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R10
		!s_r.calendar_control_a_r[`BIT_COUNTER_RUN] |=> !SECOND_PULSE_PIN)
		else $error("Pulse while stopped.");
	a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R27
		!s_r.calendar_control_a_r[`BIT_RESERVED_A] && !s_r.calendar_control_b_r[`BIT_RESERVED_B])
		else $error("Reserved bit set.");
	a_por_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R07
		wr_p |=> s_r.power_on_indicator_r == {7'h00, $past(WDATA[`BIT_POWER_ON_CHECK])})
		else $error("Indicator wrong after write.");
	a_corr_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R22
		CORRECTION_TICK_IRQ |-> $past(s_r.calendar_control_b_r[`BIT_CORR_IRQ_EN]))
		else $error("Correction interrupt while disabled.");
	a_low_speed_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R03
		s_r.count_clock_source_select_r |=> !SECOND_PULSE_PIN)
		else $error("Pulse on low-speed source.");

	// Hold and alarm each take two steps, so they are spelled out as sequences.
	sequence s_hold_settling;
		s_r.hold_state_r == HOLD_SETTLE && s_r.calendar_control_b_r[`BIT_HOLD_REQUEST];
	endsequence
	sequence s_count_edge;
		count_tick;
	endsequence
	sequence s_match_taken;
		count_tick && ALARM_MATCH && s_r.calendar_control_b_r[`BIT_ALARM_MATCH_EN];
	endsequence
	a_hold_status: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R25
		s_hold_settling ##0 s_count_edge |=> s_r.calendar_control_b_r[`BIT_HOLD_STATUS])
		else $error("Hold status missing after count edge.");
	a_alarm_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R23
		s_match_taken ##1 s_count_edge |=> s_r.calendar_control_b_r[`BIT_ALARM_FLAG])
		else $error("Alarm flag not set after match.");
	a_run_stops: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R09
		!s_r.calendar_control_a_r[`BIT_COUNTER_RUN] |-> !periodic_set)
		else $error("Periodic event while stopped.");
endmodule

// >>> testbench/test_calendar_clock_control.sv
/*
 * Self-checking bench for the calendar clock control block: register access,
 * flags, shared interrupt, correction tick and the 1 Hz pulse.
 * Assumes SUB_DIV and LOW_DIV of 1, so one count edge per system clock.
 */
`timescale 1ns/10ps
`include "calendar_clock_control_map.svh"
module test_calendar_clock_control
	import calendar_clock_control_pkg::*;
;
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [19:0] ADDR = 20'h0;
	logic WR_EN = 1'b0;
	logic RD_EN = 1'b0;
	logic [7:0] WDATA = 8'h00;
	logic ALARM_MATCH = 1'b0;
	logic [7:0] RDATA;
	logic LOW_OSC_ENABLE;
	logic SECOND_PULSE_PIN;
	logic HIGH_ACCURACY_PULSE;
	logic HOUR_FORMAT_24;
	logic CALENDAR_IRQ;
	logic CORRECTION_TICK_IRQ;
	int n_errors = 0;
	int check_count = 0;
	int n_cal;
	int n_corr;
	int n_pulse;
	logic [31:0] lfsr_r = 32'h01322a22;
	logic [7:0] val;

	// Half period of 12.5 ns gives the 40 MHz system clock.
	always #12.5 SYS_CLK = ~SYS_CLK;

	calendar_clock_control #(.SUB_DIV(1), .LOW_DIV(1)) dut (
		.SYS_CLK(SYS_CLK),
		.RST_B(RST_B),
		.ADDR(ADDR),
		.WR_EN(WR_EN),
		.RD_EN(RD_EN),
		.WDATA(WDATA),
		.ALARM_MATCH(ALARM_MATCH),
		.RDATA(RDATA),
		.LOW_OSC_ENABLE(LOW_OSC_ENABLE),
		.SECOND_PULSE_PIN(SECOND_PULSE_PIN),
		.HIGH_ACCURACY_PULSE(HIGH_ACCURACY_PULSE),
		.HOUR_FORMAT_24(HOUR_FORMAT_24),
		.CALENDAR_IRQ(CALENDAR_IRQ),
		.CORRECTION_TICK_IRQ(CORRECTION_TICK_IRQ)
	);

	// Fixed-seed shift register keeps every run identical.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Reserved bit 4 of control A never reads back.
	function automatic logic [7:0] exp_a(input logic [7:0] d);
		return d & 8'hef;
	endfunction

	// Flags were clear, so writing 1 keeps them 0; bit 2 reads 0.
	function automatic logic [7:0] exp_b(input logic [7:0] d);
		return d & 8'he1;
	endfunction

	task give_verdict;
		$display("Mismatches %0d, comparisons %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
		check_count++;
		if ((got & mask) !== (exp & mask)) begin
			n_errors++;
			$display("[ERR] %0t byte got %h want %h", $time, got, exp);
		end
	endtask

	task check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t bit got %b want %b", $time, got, exp);
		end
	endtask

	// One write strobe; returns just after the landing edge so outputs have settled.
	task wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR_EN <= 1'b1;
		@(posedge SYS_CLK);
		WR_EN <= 1'b0;
		#1;
	endtask

	task rd_chk(input logic [19:0] a, input logic [7:0] exp, input logic [7:0] mask);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD_EN <= 1'b1;
		@(posedge SYS_CLK);
		RD_EN <= 1'b0;
		#1;
		check8(RDATA, exp, mask);
	endtask

	// Counts interrupt pulses and high pulse samples over a bounded window.
	task watch(input int n);
		n_cal = 0;
		n_corr = 0;
		n_pulse = 0;
		repeat (n) begin
			@(posedge SYS_CLK);
			#1;
			if (CALENDAR_IRQ === 1'b1) n_cal++;
			if (CORRECTION_TICK_IRQ === 1'b1) n_corr++;
			if (SECOND_PULSE_PIN === 1'b1) n_pulse++;
		end
	endtask

	task alarm_window(input logic [7:0] b);
		wr(`ADDR_CALENDAR_CONTROL_B, b & 8'h7f);
		wr(`ADDR_CALENDAR_CONTROL_B, b);
		@(posedge SYS_CLK);
		ALARM_MATCH <= 1'b1;
		watch(10);
		@(posedge SYS_CLK);
		ALARM_MATCH <= 1'b0;
	endtask

	// Main sequence: reset, random register traffic, then corner cases.
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		rd_chk(`ADDR_POWER_ON_INDICATOR, 8'h00, 8'hff);
		rd_chk(`ADDR_CALENDAR_CONTROL_A, 8'h00, 8'hff);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h00, 8'hff);
		rd_chk(20'h00010, 8'h00, 8'hff);
		for (int i = 0; i < 8; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			// The counter is stopped here, so the source may change.
			wr(`ADDR_CLOCK_SOURCE, lfsr_r[23:16]);
			check1(LOW_OSC_ENABLE, lfsr_r[20]);
			val = (i == 0) ? 8'hff : lfsr_r[7:0];
			wr(`ADDR_POWER_ON_INDICATOR, val);
			rd_chk(`ADDR_POWER_ON_INDICATOR, {7'h0, val[0]}, 8'hff);
			wr(`ADDR_CALENDAR_CONTROL_A, val & 8'hef);
			rd_chk(`ADDR_CALENDAR_CONTROL_A, exp_a(val), 8'hff);
			check1(HOUR_FORMAT_24, val[3]);
			check1(HIGH_ACCURACY_PULSE, val[6]);
			val = (i == 0) ? 8'hff : lfsr_r[15:8];
			wr(`ADDR_CALENDAR_CONTROL_B, val);
			rd_chk(`ADDR_CALENDAR_CONTROL_B, exp_b(val), 8'hfd);
			wr(`ADDR_CALENDAR_CONTROL_A, 8'h00);
		end
		wr(`ADDR_CLOCK_SOURCE, 8'h00);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h00);
		wr(`ADDR_CALENDAR_CONTROL_A, 8'h80);
		// Hold request must show as hold status after a count edge.
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h01);
		repeat (4) @(posedge SYS_CLK);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h03, 8'hff);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h00);
		// Alarm with interrupt enabled, then flag write-one and write-zero.
		alarm_window(8'hc0);
		check1(n_cal != 0, 1'b1);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'hd0, 8'hfd);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'hd0);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'hd0, 8'hfd);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'hc0);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'hc0, 8'hfd);
		alarm_window(8'h80);
		check1(n_cal != 0, 1'b0);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h90, 8'hfd);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h00);
		alarm_window(8'h40);
		check1(n_cal != 0, 1'b0);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h40, 8'hfd);
		// Over a full second: half-second events, correction tick, pulse.
		wr(`ADDR_CALENDAR_CONTROL_A, 8'ha1);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h20);
		watch(70000);
		check1(n_cal >= 2, 1'b1);
		check1(n_corr != 0, 1'b1);
		check1(n_pulse != 0, 1'b1);
		// A square wave is high for exactly half of the 65536 count edges.
		check1(n_pulse == 32768, 1'b1);
		check1(SECOND_PULSE_PIN, 1'b0);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h28, 8'hfd);
		wr(`ADDR_CALENDAR_CONTROL_B, 8'h00);
		rd_chk(`ADDR_CALENDAR_CONTROL_B, 8'h00, 8'hfd);
		// Stopped counter, then low-speed source: the pulse stays low.
		wr(`ADDR_CALENDAR_CONTROL_A, 8'h20);
		watch(1000);
		check1(n_pulse != 0, 1'b0);
		wr(`ADDR_CLOCK_SOURCE, 8'h10);
		wr(`ADDR_CALENDAR_CONTROL_A, 8'ha0);
		watch(1000);
		check1(n_pulse != 0, 1'b0);
		check1(LOW_OSC_ENABLE, 1'b1);
		give_verdict();
	end
endmodule
